// [design/cid_dispatch.sv]
/*
 * Interrupt dispatch: pending flags, enables, two-level arbitration and call sequencing.
 * Assumes the core pulses instr_boundary when an instruction ends and it could vector,
 * pulses return_from_interrupt_done on the boundary that ends a return, and follows call_busy for four cycles.
 */
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module cid_dispatch
    import cid_pkg::*;
(
    input  wire logic                       clock,
    input  wire logic                       srst,
    input  wire logic                       ce,
    input  wire cid_pkg::cid_bus_t          bus,
    output logic      [cid_pkg::DATA_W-1:0] rdata,
    input  wire logic [cid_pkg::NSRC-1:0]   src_event,
    input  wire logic [1:0]                 ext_int_n,
    input  wire cid_pkg::cid_cin_t          cin,
    output cid_pkg::cid_cout_t              cout,
    output logic                            irq
);
    import cid_pkg::*;

    logic [NSRC-1:0]   pend_q;
    logic [NSRC-1:0]   pset;
    logic [NSRC-1:0]   pclr;
    logic [NSRC-1:0]   en_reg;
    logic [NSRC-1:0]   en_next;
    logic [NSRC-1:0]   pri_reg;
    logic [NSRC-1:0]   pri_next;
    logic              ea_reg;
    logic              ea_next;
    logic              grace_reg;
    logic              grace_next;
    logic [1:0]        extcfg_reg;
    logic [1:0]        extcfg_next;
    logic [NEV-1:0]    evmsk_reg;
    logic [NEV-1:0]    evmsk_next;
    logic [NEV-1:0]    ev_q;
    logic [NEV-1:0]    ev_set;
    logic [NEV-1:0]    ev_clr;
    logic [1:0]        ext_sync;
    logic [1:0]        ext_act;
    logic [1:0]        ext_prev_reg;
    logic [1:0]        ext_fall;
    cid_state_t        state_reg;
    cid_state_t        state_next;
    logic [2:0]        cnt_reg;
    logic [2:0]        cnt_next;
    logic              act_hi_reg;
    logic              act_hi_next;
    logic              act_lo_reg;
    logic              act_lo_next;
    logic              skip_reg;
    logic              skip_next;
    logic              start_reg;
    logic              start_next;
    logic              lvl_reg;
    logic              lvl_next;
    logic [SRC_W-1:0]  src_reg;
    logic [SRC_W-1:0]  src_next;
    logic [15:0]       vec_reg;
    logic [15:0]       vec_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic [NSRC-1:0]   req;
    logic [NSRC-1:0]   hi_cand;
    logic [NSRC-1:0]   lo_cand;
    logic              ea_eff;
    logic              hi_ok;
    logic              lo_ok;
    logic              win_valid;
    logic              win_hi;
    logic [SRC_W-1:0]  win_src;
    logic              may_take;
    logic              take_now;

    function automatic logic [NSRC-1:0] put_byte(input logic [NSRC-1:0] v, input int k,
                                                input logic [DATA_W-1:0] d);
        for (int b = 0; b < DATA_W; b++) begin
            if (k * DATA_W + b < NSRC) begin
                v[k * DATA_W + b] = d[b];
            end
        end
        return v;
    endfunction

    function automatic logic [DATA_W-1:0] get_byte(input logic [NSRC-1:0] v, input int k);
        logic [DATA_W-1:0] r;
        r = '0;
        for (int b = 0; b < DATA_W; b++) begin
            if (k * DATA_W + b < NSRC) begin
                r[b] = v[k * DATA_W + b];
            end
        end
        return r;
    endfunction

    function automatic logic [SRC_W-1:0] first_set(input logic [NSRC-1:0] v);
        logic [SRC_W-1:0] r;
        r = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = SRC_W'(i);
            end
        end
        return r;
    endfunction

    cid_sync #(.W(2)) u_ext_sync (
        .clock (clock),
        .srst  (srst),
        .ce    (ce),
        .d     (ext_int_n),
        .q     (ext_sync)
    );

    assign ext_act  = ~ext_sync;
    assign ext_fall = ext_act & ~ext_prev_reg;

    // Flag capture never looks at the enables.
    cid_flag #(.W(NSRC)) u_pend (
        .clock (clock),
        .srst  (srst),
        .ce    (ce),
        .set   (pset),
        .clr   (pclr),
        .q     (pend_q)
    );

    // Request gating and two-level arbitration, evaluated every cycle.
    always_comb begin
        ea_eff    = ea_reg | (grace_reg & cin.next_single);
        req       = pend_q & en_reg & {NSRC{ea_eff}};
        hi_cand   = req & pri_reg;
        lo_cand   = req & ~pri_reg;
        hi_ok     = (|hi_cand) & ~act_hi_reg;
        lo_ok     = (|lo_cand) & ~act_hi_reg & ~act_lo_reg;
        win_valid = hi_ok | lo_ok;
        win_hi    = hi_ok;
        win_src   = hi_ok ? first_set(hi_cand) : first_set(lo_cand);
        // The boundary that ends a return never vectors; one more instruction runs first.
        may_take  = cin.instr_boundary & ~cin.return_from_interrupt_done;
        take_now  = (state_reg == ST_IDLE) & win_valid & may_take;
    end

    // Pending flag sources: peripherals, pins, software writes and vectoring.
    always_comb begin
        pset = src_event;
        pclr = '0;
        pset[EXT0_IDX] = extcfg_reg[0] ? ext_fall[0] : ext_act[0];
        pclr[EXT0_IDX] = ~extcfg_reg[0] & ~ext_act[0];
        pset[EXT1_IDX] = extcfg_reg[1] ? ext_fall[1] : ext_act[1];
        pclr[EXT1_IDX] = ~extcfg_reg[1] & ~ext_act[1];
        for (int k = 0; k < 3; k++) begin
            if (bus.wr && bus.addr == A_PEND0 + ADDR_W'(k)) begin
                // Writing a one is indistinguishable from the hardware event.
                pset = pset | (put_byte('0, k, 8'hFF) & put_byte('0, k, bus.wdata));
                pclr = pclr | (put_byte('0, k, 8'hFF) & ~put_byte('0, k, bus.wdata));
            end
        end
        if (take_now && HWCLR[win_src]) begin
            // Pin sources in level mode keep following the pin instead.
            if (!((win_src == SRC_W'(EXT0_IDX) && !extcfg_reg[0]) ||
                  (win_src == SRC_W'(EXT1_IDX) && !extcfg_reg[1]))) begin
                pclr[win_src] = 1'b1;
            end
        end
    end

    // Software registers.
    always_comb begin
        en_next     = en_reg;
        pri_next    = pri_reg;
        ea_next     = ea_reg;
        extcfg_next = extcfg_reg;
        evmsk_next  = evmsk_reg;
        grace_next  = grace_reg & ~cin.instr_boundary;
        for (int k = 0; k < 3; k++) begin
            if (bus.wr && bus.addr == A_EN0 + ADDR_W'(k)) begin
                en_next = put_byte(en_reg, k, bus.wdata);
            end
            if (bus.wr && bus.addr == A_PRI0 + ADDR_W'(k)) begin
                pri_next = put_byte(pri_reg, k, bus.wdata);
            end
        end
        if (bus.wr && bus.addr == A_GEN) begin
            ea_next = bus.wdata[0];
            // Clearing the global enable leaves a one-instruction grace window.
            if (ea_reg && !bus.wdata[0]) begin
                grace_next = 1'b1;
            end
        end
        if (bus.wr && bus.addr == A_EXTCFG) begin
            extcfg_next = bus.wdata[1:0];
        end
        if (bus.wr && bus.addr == A_EVMSK) begin
            evmsk_next = bus.wdata[NEV-1:0];
        end
    end

    // Call sequencing and in-service levels.
    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        act_hi_next = act_hi_reg;
        act_lo_next = act_lo_reg;
        skip_next   = skip_reg;
        start_next  = 1'b0;
        lvl_next    = lvl_reg;
        src_next    = src_reg;
        vec_next    = vec_reg;
        if (cin.return_from_interrupt_done) begin
            // Resume point is held by the core; only the level stack unwinds here.
            skip_next = 1'b1;
            if (act_hi_reg) begin
                act_hi_next = 1'b0;
            end else begin
                act_lo_next = 1'b0;
            end
        end else if (cin.instr_boundary) begin
            skip_next = 1'b0;
        end
        unique case (state_reg)
            ST_IDLE: begin
                if (take_now) begin
                    state_next = ST_CALL;
                    cnt_next   = '0;
                    start_next = 1'b1;
                    lvl_next   = win_hi;
                    src_next   = win_src;
                    vec_next   = VEC_TAB[win_src];
                    if (win_hi) begin
                        act_hi_next = 1'b1;
                    end else begin
                        act_lo_next = 1'b1;
                    end
                end
            end
            ST_CALL: begin
                cnt_next = cnt_reg + 3'h1;
                if (cnt_reg == CALL_LAST) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    // Event status and read mux; read data stand only in the cycle after the strobe.
    always_comb begin
        ev_set             = '0;
        ev_set[EV_TAKEN]   = take_now;
        ev_set[EV_RETURN_FROM_INTERRUPT]    = cin.return_from_interrupt_done;
        ev_set[EV_PREEMPT] = take_now & win_hi & act_lo_reg;
        ev_clr = (bus.wr && bus.addr == A_EVST) ? bus.wdata[NEV-1:0] : '0;
        rdata_next = '0;
        if (bus.rd) begin
            for (int k = 0; k < 3; k++) begin
                if (bus.addr == A_PEND0 + ADDR_W'(k)) begin
                    rdata_next = get_byte(pend_q, k);
                end
                if (bus.addr == A_EN0 + ADDR_W'(k)) begin
                    rdata_next = get_byte(en_reg, k);
                end
                if (bus.addr == A_PRI0 + ADDR_W'(k)) begin
                    rdata_next = get_byte(pri_reg, k);
                end
            end
            unique case (bus.addr)
                A_GEN:    rdata_next = {7'h00, ea_reg};
                A_EXTCFG: rdata_next = {6'h00, extcfg_reg};
                A_STAT:   rdata_next = {4'h0, skip_reg, state_reg == ST_CALL,
                                        act_hi_reg, act_lo_reg};
                A_EVST:   rdata_next = {5'h00, ev_q};
                A_EVMSK:  rdata_next = {5'h00, evmsk_reg};
                A_LAST:   rdata_next = {lvl_reg, 2'h0, src_reg};
                default:  ;
            endcase
        end
    end

    cid_flag #(.W(NEV)) u_ev (
        .clock (clock),
        .srst  (srst),
        .ce    (ce),
        .set   (ev_set),
        .clr   (ev_clr),
        .q     (ev_q)
    );

    always_ff @(posedge clock) begin
        if (srst) begin
            en_reg       <= RST_SRC;
            pri_reg      <= RST_SRC;
            ea_reg       <= 1'b0;
            grace_reg    <= 1'b0;
            extcfg_reg   <= RST_EXTCFG;
            evmsk_reg    <= RST_EVMSK;
            ext_prev_reg <= 2'h0;
            state_reg    <= ST_IDLE;
            cnt_reg      <= 3'h0;
            act_hi_reg   <= 1'b0;
            act_lo_reg   <= 1'b0;
            skip_reg     <= 1'b0;
            start_reg    <= 1'b0;
            lvl_reg      <= 1'b0;
            src_reg      <= '0;
            vec_reg      <= 16'h0000;
            rdata_reg    <= '0;
        end else if (ce) begin
            en_reg       <= en_next;
            pri_reg      <= pri_next;
            ea_reg       <= ea_next;
            grace_reg    <= grace_next;
            extcfg_reg   <= extcfg_next;
            evmsk_reg    <= evmsk_next;
            ext_prev_reg <= ext_act;
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            act_hi_reg   <= act_hi_next;
            act_lo_reg   <= act_lo_next;
            skip_reg     <= skip_next;
            start_reg    <= start_next;
            lvl_reg      <= lvl_next;
            src_reg      <= src_next;
            vec_reg      <= vec_next;
            rdata_reg    <= rdata_next;
        end
    end

    assign rdata           = rdata_reg;
    assign irq             = |(ev_q & evmsk_reg);
    assign cout.call_start = start_reg;
    assign cout.call_busy  = (state_reg == ST_CALL);
    assign cout.level      = lvl_reg;
    assign cout.src        = src_reg;
    assign cout.vector     = vec_reg;

    a_call_four_cycles: assert property (@(posedge clock) disable iff (srst || !ce)
        take_now |=> cout.call_busy [*4] ##1 !cout.call_busy)
        else $error("long call did not last four cycles");

    a_vector_from_table: assert property (@(posedge clock) disable iff (srst || !ce)
        cout.call_start |-> cout.vector == VEC_TAB[cout.src])
        else $error("vector does not match source table");

    a_disabled_no_take: assert property (@(posedge clock) disable iff (srst || !ce)
        take_now |-> en_reg[win_src] && pend_q[win_src])
        else $error("vector taken for disabled or idle source");

    a_global_off_idle: assert property (@(posedge clock) disable iff (srst || !ce)
        (!ea_reg && !grace_reg) |-> !take_now)
        else $error("request taken while globally disabled");

    a_flag_capture: assert property (@(posedge clock) disable iff (srst || !ce)
        (src_event[1] && !en_reg[1]) |=> pend_q[1])
        else $error("flag not captured for disabled source");

    a_hi_not_preempt: assert property (@(posedge clock) disable iff (srst || !ce)
        act_hi_reg |-> !take_now)
        else $error("high level handler was preempted");

    a_return_from_interrupt_skip_one: assert property (@(posedge clock) disable iff (srst || !ce)
        (skip_reg && cin.instr_boundary && !cin.return_from_interrupt_done && win_valid && !cout.call_busy)
        |-> take_now) else $error("return did not re-enter after one instruction");

    a_grace_multi: assert property (@(posedge clock) disable iff (srst || !ce)
        (!ea_reg && cin.instr_boundary && !cin.next_single) |-> !take_now)
        else $error("request taken before multi-cycle instruction");

    a_hw_clear_timer: assert property (@(posedge clock) disable iff (srst || !ce)
        (take_now && win_src == 5'h01 && !src_event[1]) |=> !pend_q[1])
        else $error("hardware-cleared flag stayed set");

    a_sw_set_flag: assert property (@(posedge clock) disable iff (srst || !ce)
        (bus.wr && bus.addr == A_PEND0 && bus.wdata[5]) |=> pend_q[5])
        else $error("software write of one did not set flag");

    a_sw_keep_flag: assert property (@(posedge clock) disable iff (srst || !ce)
        (take_now && win_src == 5'h05 && !bus.wr) |=> pend_q[5])
        else $error("software-cleared flag dropped by vectoring");
endmodule

// [design/cid_flag.sv]
/*
 * Vector of sticky flags where a set in the same cycle as a clear wins.
 * Assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/1ps
module cid_flag #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] q
);
    logic [W-1:0] flag_reg;
    logic [W-1:0] flag_next;

    always_comb begin
        flag_next = (flag_reg & ~clr) | set;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            flag_reg <= '0;
        end else if (ce) begin
            flag_reg <= flag_next;
        end
    end

    assign q = flag_reg;
endmodule

// [design/cid_pkg.sv]
/*
 * Shared constants and carrier types of the interrupt dispatch block.
 * Assumes one 50 MHz system clock and an 8-bit register port with a 5-bit address.
 */
package cid_pkg;
    localparam int NSRC   = 20;
    localparam int SRC_W  = 5;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int NEV    = 3;

    localparam logic [ADDR_W-1:0] A_PEND0  = 5'h00;
    localparam logic [ADDR_W-1:0] A_EN0    = 5'h03;
    localparam logic [ADDR_W-1:0] A_GEN    = 5'h06;
    localparam logic [ADDR_W-1:0] A_PRI0   = 5'h07;
    localparam logic [ADDR_W-1:0] A_EXTCFG = 5'h0A;
    localparam logic [ADDR_W-1:0] A_STAT   = 5'h0B;
    localparam logic [ADDR_W-1:0] A_EVST   = 5'h0C;
    localparam logic [ADDR_W-1:0] A_EVMSK  = 5'h0D;
    localparam logic [ADDR_W-1:0] A_LAST   = 5'h0E;

    localparam logic [NSRC-1:0] RST_SRC    = 20'h00000;
    localparam logic [1:0]      RST_EXTCFG = 2'h0;
    localparam logic [NEV-1:0]  RST_EVMSK  = 3'h0;
    localparam logic [2:0]      CALL_LAST  = 3'h3;

    // Event bits of the event status register.
    localparam int EV_TAKEN = 0;
    localparam int EV_RETURN_FROM_INTERRUPT  = 1;
    localparam int EV_PREEMPT = 2;

    // Sources whose flag hardware clears on vectoring; the two pin sources only in edge mode.
    localparam logic [NSRC-1:0] HWCLR = 20'h4000F;
    localparam int EXT0_IDX = 0;
    localparam int EXT1_IDX = 2;

    // Index is the fixed rank: lower index wins within a level.
    localparam logic [15:0] VEC_TAB [NSRC] = '{
        16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023,
        16'h002B, 16'h0033, 16'h003B, 16'h0043, 16'h004B,
        16'h0053, 16'h005B, 16'h0063, 16'h0073, 16'h007B,
        16'h0083, 16'h0093, 16'h008B, 16'h009B, 16'h00A3};

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } cid_bus_t;

    typedef struct packed {
        logic instr_boundary;
        logic next_single;
        logic return_from_interrupt_done;
    } cid_cin_t;

    typedef struct packed {
        logic             call_start;
        logic             call_busy;
        logic             level;
        logic [SRC_W-1:0] src;
        logic [15:0]      vector;
    } cid_cout_t;

    typedef enum logic {ST_IDLE, ST_CALL} cid_state_t;
endpackage

// [design/cid_sync.sv]
/*
 * Two-stage synchroniser for pin inputs.
 * Assumes the inputs are asynchronous to clock; only the second stage is read outside.
 */
`timescale 1ns/1ps
module cid_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;

    // Pins idle high, so reset to all ones avoids a false edge at release.
    always_ff @(posedge clock) begin
        if (srst) begin
            s1_reg <= '1;
            s2_reg <= '1;
        end else if (ce) begin
            s1_reg <= d;
            s2_reg <= s1_reg;
        end
    end

    assign q = s2_reg;
endmodule

// [sim/cid_core_model.sv]
/*
 * Behavioural core sequencer that feeds instruction boundaries to the dispatch block.
 * Assumes a take is answered with call_busy in the cycle after the boundary.
 */
`timescale 1ns/1ps
module cid_core_model
    import cid_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               srst,
    input  wire logic               run,
    input  wire logic               slow,
    input  wire logic               single,
    input  wire logic               return_from_interrupt_req,
    input  wire cid_pkg::cid_cout_t cout,
    output cid_pkg::cid_cin_t       cin
);
    logic [1:0] gap_reg;
    logic       return_from_interrupt_reg;

    // An idle cycle always follows a boundary, so call_busy is seen before the next one.
    always_ff @(posedge clock) begin
        if (srst) begin
            cin <= '0;
            gap_reg <= 2'h0;
            return_from_interrupt_reg <= 1'b0;
        end else if (gap_reg != 2'h0 || !run || cout.call_busy) begin
            cin.instr_boundary <= 1'b0;
            cin.return_from_interrupt_done <= 1'b0;
            gap_reg <= (gap_reg != 2'h0) ? gap_reg - 2'h1 : 2'h0;
            return_from_interrupt_reg <= return_from_interrupt_reg | return_from_interrupt_req;
        end else begin
            cin.instr_boundary <= 1'b1;
            cin.next_single <= single;
            cin.return_from_interrupt_done <= return_from_interrupt_reg | return_from_interrupt_req;
            return_from_interrupt_reg <= 1'b0;
            gap_reg <= slow ? 2'h3 : 2'h1;
        end
    end
endmodule

// [sim/cid_dispatch_tb_top.sv]
/*
 * Self-checking bench of the interrupt dispatch block.
 * Assumes the design package, design modules and cid_core_model are compiled first.
 */
`timescale 1ns/1ps
module cid_dispatch_tb_top;
    import cid_pkg::*;
    logic              clock;
    logic              srst;
    cid_bus_t          bus;
    logic [DATA_W-1:0] rdata;
    logic [NSRC-1:0]   src_event;
    logic [1:0]        ext_int_n;
    cid_cin_t          cin;
    cid_cout_t         cout;
    logic              irq;
    logic              run;
    logic              slow;
    logic              single;
    logic              return_from_interrupt_req;
    int                fail_count;
    int                n_checks;

    cid_dispatch dut (.clock(clock), .srst(srst), .ce(1'b1), .bus(bus), .rdata(rdata),
        .src_event(src_event), .ext_int_n(ext_int_n), .cin(cin), .cout(cout), .irq(irq));
    cid_core_model core (.clock(clock), .srst(srst), .run(run), .slow(slow),
        .single(single), .return_from_interrupt_req(return_from_interrupt_req), .cout(cout), .cin(cin));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= {1'b1, 1'b0, a, d};
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
        @(posedge clock);
        bus <= {1'b0, 1'b1, a, 8'h00};
        @(posedge clock);
        bus.rd <= 1'b0;
        #1 chk({8'h00, rdata}, {8'h00, exp});
    endtask

    task automatic pulse(input logic [NSRC-1:0] m);
        @(posedge clock);
        src_event <= m;
        @(posedge clock);
        src_event <= '0;
    endtask

    task automatic do_return_from_interrupt;
        @(posedge clock);
        return_from_interrupt_req <= 1'b1;
        @(posedge clock);
        return_from_interrupt_req <= 1'b0;
    endtask

    task automatic wait_call(input logic [15:0] v, input logic [4:0] s, input logic l);
        int n;
        n = 0;
        do begin
            @(posedge clock);
            #1 n++;
        end while (cout.call_start !== 1'b1 && n < 60);
        chk1(cout.call_start, 1'b1);
        chk(cout.vector, v);
        chk({11'h000, cout.src}, {11'h000, s});
        chk1(cout.level, l);
        n = 0;
        while (cout.call_busy === 1'b1 && n < 9) begin
            @(posedge clock);
            #1 n++;
        end
        chk(16'(n), 16'h0004);
    endtask

    task automatic no_call;
        repeat (20) begin
            @(posedge clock);
            #1 chk1(cout.call_start, 1'b0);
        end
    endtask

    task automatic t_reset;
        rdchk(A_EN0, 8'h00);
        rdchk(A_EVMSK, 8'h00);
        wr(A_STAT, 8'hFF);
        rdchk(A_STAT, 8'h00);
        rdchk(5'h1F, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_capture;
        wr(A_GEN, 8'h01);
        ext_int_n <= 2'b10;
        pulse(20'h00002);
        rdchk(A_PEND0, 8'h03);
        no_call;
        ext_int_n <= 2'b11;
        wr(A_PEND0, 8'h00);
        $display("test capture done");
    endtask

    task automatic t_vector;
        slow <= 1'b1;
        wr(A_EN0, 8'h02);
        pulse(20'h00002);
        wait_call(16'h000B, 5'd1, 1'b0);
        rdchk(A_PEND0, 8'h00);
        do_return_from_interrupt;
        slow <= 1'b0;
        $display("test vector done");
    endtask

    task automatic t_global;
        wr(A_GEN, 8'h00);
        wr(A_EN0, 8'h20);
        wr(A_PEND0, 8'h20);
        no_call;
        wr(A_GEN, 8'h01);
        wait_call(16'h002B, 5'd5, 1'b0);
        rdchk(A_PEND0, 8'h20);
        do_return_from_interrupt;
        wait_call(16'h002B, 5'd5, 1'b0);
        wr(A_PEND0, 8'h00);
        do_return_from_interrupt;
        $display("test global done");
    endtask

    task automatic t_prio;
        wr(A_EVST, 8'h07);
        wr(A_PRI0, 8'h80);
        wr(A_EN0, 8'hD0);
        pulse(20'h00050);
        wait_call(16'h0023, 5'd4, 1'b0);
        pulse(20'h00080);
        wait_call(16'h003B, 5'd7, 1'b1);
        wr(A_PEND0, 8'h40);
        no_call;
        do_return_from_interrupt;
        no_call;
        do_return_from_interrupt;
        wait_call(16'h0033, 5'd6, 1'b0);
        wr(A_PEND0, 8'h00);
        do_return_from_interrupt;
        rdchk(A_EVST, 8'h07);
        chk1(irq, 1'b0);
        wr(A_EVMSK, 8'h04);
        #1 chk1(irq, 1'b1);
        wr(A_EVST, 8'h04);
        #1 chk1(irq, 1'b0);
        wr(A_EN0, 8'h00);
        $display("test priority done");
    endtask

    // The grace window only lasts to the next boundary, so the core is paused during setup.
    task automatic t_grace;
        run <= 1'b0;
        wr(A_EN0 + 5'h01, 8'h01);
        wr(A_PEND0 + 5'h01, 8'h01);
        wr(A_GEN, 8'h00);
        run <= 1'b1;
        wait_call(16'h0043, 5'd8, 1'b0);
        rdchk(A_GEN, 8'h00);
        wr(A_PEND0 + 5'h01, 8'h00);
        do_return_from_interrupt;
        repeat (8) @(posedge clock);
        run <= 1'b0;
        wr(A_GEN, 8'h01);
        wr(A_PEND0 + 5'h01, 8'h01);
        wr(A_GEN, 8'h00);
        single <= 1'b0;
        run <= 1'b1;
        no_call;
        $display("test grace done");
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        fail_count = 0;
        n_checks = 0;
        srst = 1'b1;
        bus = '0;
        src_event = '0;
        ext_int_n = 2'b11;
        run = 1'b1;
        slow = 1'b0;
        single = 1'b1;
        return_from_interrupt_req = 1'b0;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        t_reset;
        t_capture;
        t_vector;
        t_global;
        t_prio;
        t_grace;
        conclude;
    end

    initial begin
        #200000;
        fail_count++;
        conclude;
    end
endmodule
